// [hw/lssp_if.sv]
// link wires between master and slave ends
`timescale 1ns/1ns
`default_nettype none
interface lssp_if;
	logic sclk;
	logic sel;
	logic mosi;
	logic miso;
	modport slave (input sclk, input sel, input mosi, output miso);
	modport master (output sclk, output sel, output mosi, input miso);
endinterface : lssp_if
`default_nettype wire

// [hw/lssp_master.sv]
// host end: spi master issuing legacy read and write cycles
`timescale 1ns/1ns
`default_nettype none
module lssp_master
	import lssp_pkg::*;
#(
	parameter int DATA_W = LSSP_DATA_W,
	parameter int SCLK_DIV = LSSP_SCLK_DIV
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// link
	lssp_if.master link,
	// request
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_read_i,
	input wire logic req_data_reg_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	// answer
	output logic done_o,
	output logic [DATA_W-1:0] rdata_o,
	output logic retry_o
);
	initial
	begin
		if (DATA_W != LSSP_DATA_W || SCLK_DIV < 2)
			$error("lssp_master: unsupported parameters");
	end
	typedef enum logic [1:0] {LSSP_IDLE, LSSP_SHIFT, LSSP_GAP} lssp_state_e;
	lssp_state_e state;
	logic [7:0] div;
	logic [3:0] bitn;
	logic [LSSP_FRAME_BITS-1:0] sho;
	logic [DATA_W-1:0] shi;
	logic [1:0] miso_s;
	logic sclk, sel, done, retry;
	wire logic half = (div == 8'(SCLK_DIV / 2 - 1));
	wire logic full = (div == 8'(SCLK_DIV - 1));
	assign req_ready_o = (state == LSSP_IDLE);
	assign link.sclk = sclk;
	assign link.sel = sel;
	assign link.mosi = sho[LSSP_FRAME_BITS-1];
	assign done_o = done;
	assign retry_o = retry;
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state <= LSSP_IDLE;
			div <= 8'h00;
			bitn <= 4'h0;
			sho <= '0;
			shi <= 8'h00;
			miso_s <= 2'h0;
			sclk <= 1'b0;
			sel <= 1'b0;
			done <= 1'b0;
			retry <= 1'b0;
			rdata_o <= 8'h00;
		end
		else
		begin
			miso_s <= {miso_s[0], link.miso};
			done <= 1'b0;
			div <= full ? 8'h00 : 8'(div + 8'h1);
			case (state)
				LSSP_IDLE:
				begin
					div <= 8'h00;
					if (req_valid_i)
					begin
						sel <= 1'b1;
						sho <= {req_read_i, req_data_reg_i, req_wdata_i, 1'b0};
						bitn <= 4'h0;
						state <= LSSP_SHIFT;
					end
				end
				LSSP_SHIFT:
				begin
					if (half)
						sclk <= 1'b1;
					if (full)
					begin
						sclk <= 1'b0;
						sho <= {sho[LSSP_FRAME_BITS-2:0], 1'b0};
						// sampled late: miso passes the synchroniser
						if (bitn > 4'(LSSP_BIT_DATA0)
							&& bitn <= 4'(LSSP_BIT_STAT))
							shi <= {shi[DATA_W-2:0], miso_s[1]};
						bitn <= 4'(bitn + 4'h1);
						if (bitn == 4'(LSSP_FRAME_BITS - 1))
						begin
							sel <= 1'b0;
							state <= LSSP_GAP;
						end
					end
				end
				LSSP_GAP:
				begin
					// status bit needs one more sampling period
					if (full)
					begin
						if (bitn == 4'(LSSP_FRAME_BITS))
						begin
							rdata_o <= shi;
							retry <= miso_s[1];
							done <= 1'b1;
							bitn <= 4'(bitn + 4'h1);
						end
						else
							state <= LSSP_IDLE;
					end
				end
				default:
					state <= LSSP_IDLE;
			endcase
		end
	end
endmodule : lssp_master
`default_nettype wire

// [hw/lssp_pkg.sv]
// shared constants for the legacy spi slave port
package lssp_pkg;
	localparam int LSSP_DATA_W = 8;
	localparam int LSSP_FRAME_BITS = 11;
	localparam int LSSP_BIT_DIR = 0;
	localparam int LSSP_BIT_REG = 1;
	localparam int LSSP_BIT_DATA0 = 2;
	localparam int LSSP_BIT_STAT = 10;
	localparam logic LSSP_DIR_READ = 1'b1;
	localparam logic LSSP_DIR_WRITE = 1'b0;
	localparam logic LSSP_REG_DATA = 1'b1;
	localparam logic LSSP_REG_STATUS = 1'b0;
	localparam logic LSSP_STAT_OK = 1'b0;
	localparam logic LSSP_STAT_RETRY = 1'b1;
	localparam int LSSP_SCLK_DIV = 4;
	localparam int LSSP_GAP_SCLK = 1;
	localparam int LSSP_BUF_DEPTH = 2;
endpackage : lssp_pkg

// [hw/lssp_slave.sv]
// device end: legacy spi slave with two-entry receive buffer
// Notes on behaviour
// - master holds select high whole cycle
// - select low at least two sclk periods between cycles
// - first bit high means read
// - first bit low means write
// - second bit high data, low status
// - read data shifted out msb first
// - trailing bit low new, high old
// - write data shifted in msb first
// - trailing bit low accepted, high full
`timescale 1ns/1ns
`default_nettype none
module lssp_slave
	import lssp_pkg::*;
#(
	parameter int DATA_W = LSSP_DATA_W
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// link
	lssp_if.slave link,
	// received words (data register writes)
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	output logic [DATA_W-1:0] rx_data_o,
	// status register writes
	output logic stat_wr_o,
	output logic [DATA_W-1:0] stat_wr_data_o,
	// words to send (data register reads, status_i for status reads)
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic [DATA_W-1:0] tx_data_i,
	input wire logic [DATA_W-1:0] status_i
);
	initial
	begin
		if (DATA_W != LSSP_DATA_W)
			$error("lssp_slave: frame layout fixed at eight data bits");
	end
	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] sclk_s, sel_s, mosi_s;
	logic sclk_d;
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sclk_s <= 2'h0;
			sel_s <= 2'h0;
			mosi_s <= 2'h0;
			sclk_d <= 1'b0;
		end
		else
		begin
			sclk_s <= {sclk_s[0], link.sclk};
			sel_s <= {sel_s[0], link.sel};
			mosi_s <= {mosi_s[0], link.mosi};
			sclk_d <= sclk_s[1];
		end
	end
	wire logic sel = sel_s[1];
	wire logic rise = sclk_s[1] & ~sclk_d & sel;
	wire logic fall = ~sclk_s[1] & sclk_d & sel;
	wire logic mosi = mosi_s[1];
	////////////////////////////////////////////////////////////////////////
	// two-entry receive buffer
	logic [DATA_W-1:0] buf_mem [LSSP_BUF_DEPTH];
	logic wp, rp;
	logic [1:0] cnt;
	logic push;
	logic [DATA_W-1:0] push_data;
	wire logic buf_full = (cnt == 2'h2);
	wire logic pop = rx_valid_o & rx_ready_i;
	assign rx_valid_o = (cnt != 2'h0);
	assign rx_data_o = buf_mem[rp];
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
		end
		else
		begin
			if (push)
				wp <= ~wp;
			if (pop)
				rp <= ~rp;
			cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
		end
	end
	always_ff @(posedge mclk_i)
	begin
		if (push)
			buf_mem[wp] <= push_data;
	end
	////////////////////////////////////////////////////////////////////////
	// frame engine
	logic [3:0] bitn;
	logic dir, regsel, fresh;
	logic [DATA_W-1:0] shin, shout, tx_hold;
	logic miso;
	logic stat_wr;
	// refusal is latched when the word is offered, not at the status bit:
	// a push that fills the last free entry was still accepted
	logic refused;
	wire logic data_last = rise & (bitn == 4'(LSSP_BIT_STAT - 1));
	wire logic wr_done = data_last & (dir == LSSP_DIR_WRITE);
	wire logic wr_data = wr_done & (regsel == LSSP_REG_DATA);
	assign push = wr_data & ~buf_full;
	assign push_data = {shin[DATA_W-2:0], mosi};
	wire logic reg_taken = rise & (bitn == 4'(LSSP_BIT_REG));
	wire logic rd_data = reg_taken & (dir == LSSP_DIR_READ)
		& (mosi == LSSP_REG_DATA);
	assign tx_ready_o = rd_data;
	assign link.miso = miso;
	assign stat_wr_o = stat_wr;
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			bitn <= 4'h0;
			dir <= 1'b0;
			regsel <= 1'b0;
			fresh <= 1'b0;
			shin <= 8'h00;
			shout <= 8'h00;
			tx_hold <= 8'h00;
			miso <= 1'b0;
			stat_wr <= 1'b0;
			stat_wr_data_o <= 8'h00;
			refused <= 1'b0;
		end
		else
		begin
			stat_wr <= 1'b0;
			if (!sel)
				bitn <= 4'h0;
			else if (rise)
				bitn <= 4'(bitn + 4'h1);
			if (rise && bitn == 4'(LSSP_BIT_DIR))
				dir <= mosi;
			if (reg_taken)
			begin
				regsel <= mosi;
				if (rd_data && tx_valid_i)
				begin
					tx_hold <= tx_data_i;
					shout <= tx_data_i;
					fresh <= 1'b1;
				end
				else if (mosi == LSSP_REG_DATA)
				begin
					shout <= tx_hold;
					fresh <= 1'b0;
				end
				else
				begin
					shout <= status_i;
					fresh <= 1'b1;
				end
			end
			if (rise)
				shin <= {shin[DATA_W-2:0], mosi};
			if (wr_done)
				refused <= wr_data & buf_full;
			if (wr_done && regsel == LSSP_REG_STATUS)
			begin
				stat_wr <= 1'b1;
				stat_wr_data_o <= push_data;
			end
			// miso changes on falling edge, master samples on a later falling edge
			if (fall && bitn >= 4'(LSSP_BIT_DATA0)
				&& bitn < 4'(LSSP_BIT_STAT) && dir == LSSP_DIR_READ)
			begin
				miso <= shout[DATA_W-1];
				shout <= {shout[DATA_W-2:0], 1'b0};
			end
			else if (fall && bitn == 4'(LSSP_BIT_STAT))
			begin
				if (dir == LSSP_DIR_READ)
					miso <= fresh ? LSSP_STAT_OK : LSSP_STAT_RETRY;
				else
					miso <= refused ? LSSP_STAT_RETRY : LSSP_STAT_OK;
			end
		end
	end
endmodule : lssp_slave
`default_nettype wire

// [verification/legacy_spi_slave_port_bench.sv]
// self-checking bench joining master and slave ends
`timescale 1ns/1ns
`default_nettype none
module legacy_spi_slave_port_bench;
	import lssp_pkg::*;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic req_read_i = 1'b0;
	logic req_data_reg_i = 1'b0;
	logic [7:0] req_wdata_i = 8'h00;
	logic rx_ready_i = 1'b0;
	logic tx_valid_i = 1'b0;
	logic [7:0] tx_data_i = 8'h00;
	logic [7:0] status_i = 8'h00;
	logic req_ready_o, done_o, retry_o, rx_valid_o, stat_wr_o, tx_ready_o;
	logic [7:0] rdata_o, rx_data_o, stat_wr_data_o;
	logic [31:0] lf = 32'hA6C9F6C1;
	logic [9:0] e;
	logic [9:0] qa[$];
	logic [7:0] qr[$], qs[$];
	int miscompares = 0;
	int checked = 0;
	initial forever #25 mclk_i = ~mclk_i;
	lssp_if lssp_if_inst();
	lssp_slave lssp_slave_inst (.link(lssp_if_inst), .*);
	lssp_master lssp_master_inst (.link(lssp_if_inst), .*);
	lssp_checker lssp_checker_inst (.mclk_i(mclk_i), .reset_i(reset_i),
		.sclk(lssp_if_inst.sclk), .sel(lssp_if_inst.sel),
		.mosi(lssp_if_inst.mosi), .miso(lssp_if_inst.miso));
	//////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic cmp(input string n, input logic [8:0] x, g);
		checked++;
		if (g !== x)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask : cmp
	task automatic end_sim();
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// notes expectations first, so the monitor never runs ahead
	task automatic op(input logic rd, dr, input logic [7:0] wd, ed,
		input logic er);
		qa.push_back({rd, ed, er});
		if (!rd && dr && !er)
			qr.push_back(wd);
		if (!rd && !dr)
			qs.push_back(wd);
		req_valid_i <= 1'b1;
		req_read_i <= rd;
		req_data_reg_i <= dr;
		req_wdata_i <= wd;
		@(posedge mclk_i);
		while (req_ready_o !== 1'b1)
			@(posedge mclk_i);
		req_valid_i <= 1'b0;
		@(posedge mclk_i);
		while (done_o !== 1'b1)
			@(posedge mclk_i);
	endtask : op
	//////////////////////////////////////////////
	always @(posedge mclk_i)
	begin
		if (done_o === 1'b1)
		begin
			e = qa.pop_front();
			cmp("answer", e[8:0], {e[9] ? rdata_o : e[8:1], retry_o});
		end
		if (rx_valid_o === 1'b1 && rx_ready_i)
			cmp("rx", {qr.pop_front(), 1'b0}, {rx_data_o, 1'b0});
		if (stat_wr_o === 1'b1)
			cmp("stat", {qs.pop_front(), 1'b0}, {stat_wr_data_o, 1'b0});
	end
	initial
	begin
		#200000;
		miscompares++;
		end_sim();
	end
	initial
	begin
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		// receiver stalled: third word must bounce off the full buffer
		for (int i = 0; i < 3; i++)
		begin
			lf = nxt(lf);
			op(1'b0, 1'b1, lf[7:0], 8'h00, i == 2);
		end
		rx_ready_i <= 1'b1;
		op(1'b0, 1'b1, lf[7:0], 8'h00, 1'b0);
		tx_valid_i <= 1'b1;
		tx_data_i <= lf[15:8];
		op(1'b1, 1'b1, 8'h00, lf[15:8], 1'b0);
		tx_valid_i <= 1'b0;
		op(1'b1, 1'b1, 8'h00, lf[15:8], 1'b1);
		// every direction and register pairing with random data
		for (int i = 0; i < 12; i++)
		begin
			lf = nxt(lf);
			tx_valid_i <= 1'b1;
			tx_data_i <= lf[7:0];
			status_i <= lf[7:0];
			op(lf[8], lf[9], lf[7:0], lf[7:0], 1'b0);
		end
		@(posedge mclk_i);
		cmp("left", 9'h000, 9'(qa.size() + qr.size() + qs.size()));
		end_sim();
	end
endmodule : legacy_spi_slave_port_bench
`default_nettype wire

// [verification/lssp_checker.sv]
// link protocol assertions across master and slave ends
`timescale 1ns/1ns
`default_nettype none
module lssp_checker
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// link wires
	input wire logic sclk,
	input wire logic sel,
	input wire logic mosi,
	input wire logic miso
);
	logic sclk_q;
	logic [3:0] edges;
	wire logic sclk_rise = sclk && !sclk_q;
	// counts edges seen by the master clock, not by the slave sync
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sclk_q <= 1'b0;
			edges <= 4'h0;
		end
		else
		begin
			sclk_q <= sclk;
			edges <= !sel ? 4'h0 : edges + {3'h0, sclk_rise};
		end
	end
	//////////////////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	chk_idle_clock: assert property (!sel |-> !sclk)
		else $error("clock outside frame");
	chk_sel_whole: assert property (sel && edges < 4'hB |=> sel)
		else $error("select dropped early");
	chk_gap_low: assert property ($fell(sel) |-> !sel [*4])
		else $error("gap too short");
	chk_clock_high: assert property ($rose(sclk) |-> sclk ##1 sclk ##1 !sclk)
		else $error("clock high time");
	chk_clock_low: assert property ($fell(sclk) |-> !sclk [*2])
		else $error("clock low time");
	chk_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi moved while clock high");
	chk_edge_count: assert property ($fell(sel) |-> edges == 4'hB)
		else $error("frame edge count");
	chk_frame_start: assert property ($rose(sel) |-> ##[1:8] sclk_rise)
		else $error("no first edge");
endmodule : lssp_checker
`default_nettype wire
